// file: inc/p6hs_if.sv
// Interface joining the register master end and the pin routing end.
`timescale 1ns/1ps
interface p6hs_if;
	import p6hs_pkg::*;
	logic wr_en; // Write strobe, one cycle.
	logic rd_en; // Read strobe, one cycle.
	logic [23:0] addr; // Byte address.
	logic [7:0] wdata; // Write data.
	logic [7:0] rdata; // Read data, valid the cycle after rd_en.
	logic rvalid; // Read data valid pulse.
	modport device (input wr_en, input rd_en, input addr, input wdata, output rdata, output rvalid);
	modport master (output wr_en, output rd_en, output addr, output wdata, input rdata, input rvalid);
endinterface : p6hs_if

// file: inc/p6hs_pkg.sv
// Package of constants and types shared by the port-6 upper pin function select ends.
// What this block does
// RULE1 - Low pair register: pin5 bits 6-4, pin4 2-0
// RULE2 - High pair register: pin7 bits 6-4, pin6 2-0
// RULE3 - Bits 7 and 3 read zero, written zero
// RULE4 - Pin5 codes 001-100: ext_interrupt_req_5, async clocks, sync clock
// RULE5 - Pin5 101 timer d0 b1, 110 d1 disable
// RULE6 - Pin4 codes 001-100: ext_interrupt_req_4, disable, timer c, data
// RULE7 - Pin4 101 timer d0 a1, 110 timer a
// RULE8 - Pin7 codes 001-100: ext_interrupt_req_7, transmit outputs, sync io
// RULE9 - Pin7 101 timer d0 d1, 110 converter2 trigger
// RULE10 - Pin6 codes 001-100: ext_interrupt_req_6, receive inputs, chip select
// RULE11 - Pin6 101 timer d0 c1, 110 converter1 trigger
// RULE12 - Timer c code optional, software avoids it
// RULE13 - Small variants: pin5 code 110 unavailable
// RULE14 - Without converter2: pin7 code 110 unavailable
// RULE15 - No open drain for sync clock/data outputs
// RULE16 - No open drain for chip select output
// RULE17 - Codes 000 and 111 route nothing
// RULE18 - Route pin only to chosen peripheral
package p6hs_pkg;

	// Register byte addresses.
	localparam logic [23:0] P6HS_LOW_PAIR_ADDR = 24'hff0056;
	localparam logic [23:0] P6HS_HIGH_PAIR_ADDR = 24'hff0057;
	localparam logic [7:0] P6HS_RESET_VALUE = 8'h55;
	// Field positions.
	localparam int P6HS_UPPER_LSB = 4;
	localparam int P6HS_LOWER_LSB = 0;
	localparam int P6HS_FIELD_W = 3;
	// Selector codes.
	localparam logic [2:0] P6HS_CODE_NONE0 = 3'h0;
	localparam logic [2:0] P6HS_CODE_IRQ = 3'h1;
	localparam logic [2:0] P6HS_CODE_SEL2 = 3'h2;
	localparam logic [2:0] P6HS_CODE_SEL3 = 3'h3;
	localparam logic [2:0] P6HS_CODE_SYNC = 3'h4;
	localparam logic [2:0] P6HS_CODE_TIMER_D = 3'h5;
	localparam logic [2:0] P6HS_CODE_SEL6 = 3'h6;
	localparam logic [2:0] P6HS_CODE_NONE7 = 3'h7;
	localparam logic [2:0] P6HS_DEFAULT_CODE = 3'h5;
	// Number of routed pins, pin 4 at index 0.
	localparam int P6HS_PINS = 4;
	// Functions per pin, one per legal code 1..6.
	localparam int P6HS_FUNCS = 6;

	// Per-function peripheral side signals, index = code - 1.
	typedef struct packed {
		logic [P6HS_FUNCS-1:0] out;
		logic [P6HS_FUNCS-1:0] oe;
	} p6hs_periph_drive_t;

endpackage : p6hs_pkg

// file: rtl/p6hs_master.sv
// Software-side end: issues register writes and reads, keeps reserved bits zero.
`timescale 1ns/1ps
module p6hs_master (
	input wire logic clock_in,
	input wire logic srst_in,
	p6hs_if.master bus,
	input wire logic req_in,
	input wire logic req_write_in,
	input wire logic req_high_in,
	input wire logic [2:0] upper_code_in,
	input wire logic [2:0] lower_code_in,
	output logic busy_out,
	output logic [7:0] read_data_out,
	output logic read_done_out
);
	import p6hs_pkg::*;

	// All state of this end.
	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [23:0] addr;
		logic [7:0] wdata;
		logic busy;
		logic [7:0] rdata;
		logic done;
	} p6hs_mstate_t;

	p6hs_mstate_t st; // Registered state.
	p6hs_mstate_t next_st; // Next state.

	////////////////////////////////////////////////////////////////////////
	// Request handling; strobes last one cycle, reads wait for rvalid.
	always_comb begin
		next_st = st;
		next_st.wr_en = 1'b0;
		next_st.rd_en = 1'b0;
		next_st.done = 1'b0;
		if (st.busy && bus.rvalid) begin
			// The read answer is captured and the end becomes free.
			next_st.rdata = bus.rdata;
			next_st.done = 1'b1;
			next_st.busy = 1'b0;
		end else if (req_in && !st.busy) begin
			next_st.addr = req_high_in ? P6HS_HIGH_PAIR_ADDR : P6HS_LOW_PAIR_ADDR;
			if (req_write_in) begin
				// Reserved bits always written zero; prohibited codes are the user's to avoid.
				next_st.wr_en = 1'b1; // RULE3
				next_st.wdata = {1'b0, upper_code_in, 1'b0, lower_code_in}; // RULE3
			end else begin
				next_st.rd_en = 1'b1;
				next_st.busy = 1'b1;
			end
		end
	end

	// State register.
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign bus.wr_en = st.wr_en;
	assign bus.rd_en = st.rd_en;
	assign bus.addr = st.addr;
	assign bus.wdata = st.wdata;
	assign busy_out = st.busy;
	assign read_data_out = st.rdata;
	assign read_done_out = st.done;

endmodule : p6hs_master

// file: rtl/p6hs_router.sv
// Device end: the two selector registers and the pin-to-peripheral routing for port 6 pins 4 to 7.
`timescale 1ns/1ps
module p6hs_router #(
	parameter bit HAS_TIMER_C = 1'b1, // Variant has timer C.
	parameter bit HAS_TIMER_D1 = 1'b1, // Variant has timer D unit 1.
	parameter bit HAS_CONVERTER2 = 1'b1 // Variant has the second converter.
) (
	input wire logic clock_in,
	input wire logic srst_in,
	p6hs_if.device bus,
	// Pin side, index 0 is pin 4 up to index 3 for pin 7.
	input wire logic [p6hs_pkg::P6HS_PINS-1:0] pin_in,
	output logic [p6hs_pkg::P6HS_PINS-1:0] pin_out,
	output logic [p6hs_pkg::P6HS_PINS-1:0] pin_oe_out,
	// Peripheral drive, one packed entry per pin, function index = code - 1.
	input wire p6hs_pkg::p6hs_periph_drive_t [p6hs_pkg::P6HS_PINS-1:0] periph_drive_in,
	// Peripheral input, one bit per pin and function; unselected ones held low.
	output logic [p6hs_pkg::P6HS_PINS-1:0][p6hs_pkg::P6HS_FUNCS-1:0] periph_in_out,
	output logic [7:0] low_pair_out,
	output logic [7:0] high_pair_out
);
	import p6hs_pkg::*;

	// All state of the device end.
	typedef struct packed {
		logic [P6HS_PINS-1:0][P6HS_FIELD_W-1:0] field; // Fields for pins 4..7.
		logic [7:0] rdata;
		logic rvalid;
		logic [P6HS_PINS-1:0] pin_sync1; // First synchroniser stage.
		logic [P6HS_PINS-1:0] pin_sync2; // Second synchroniser stage.
		logic [P6HS_PINS-1:0] pout;
		logic [P6HS_PINS-1:0] poe;
		logic [P6HS_PINS-1:0][P6HS_FUNCS-1:0] pin_route;
	} p6hs_rstate_t;

	p6hs_rstate_t st; // Registered state.
	p6hs_rstate_t next_st; // Next state.

	// Legal codes map to one-hot function select; prohibited and missing ones map to nothing.
	function automatic logic [P6HS_FUNCS-1:0] p6hs_decode(input logic [2:0] code, input int pin);
		logic [P6HS_FUNCS-1:0] hot;
		hot = '0;
		if (code != P6HS_CODE_NONE0 && code != P6HS_CODE_NONE7) begin // RULE17
			hot[code - 3'h1] = 1'b1; // RULE4 RULE6 RULE8 RULE10 RULE5 RULE7 RULE9 RULE11
		end
		// Routings absent from the variant are left unconnected.
		if (pin == 0 && code == P6HS_CODE_SEL3 && !HAS_TIMER_C) begin
			hot = '0; // RULE12
		end
		if (pin == 1 && code == P6HS_CODE_SEL6 && !HAS_TIMER_D1) begin
			hot = '0; // RULE13
		end
		if (pin == 3 && code == P6HS_CODE_SEL6 && !HAS_CONVERTER2) begin
			hot = '0; // RULE14
		end
		return hot;
	endfunction : p6hs_decode

	////////////////////////////////////////////////////////////////////////
	// Register access and routing; every output is registered, so drive routing adds one cycle and pin input routing three, through the synchroniser.
	always_comb begin
		logic [P6HS_FUNCS-1:0] sel;
		sel = '0;
		next_st = st;
		next_st.rvalid = 1'b0;
		next_st.pin_sync1 = pin_in;
		next_st.pin_sync2 = st.pin_sync1;
		// Writes store only the field bits; reserved bits are dropped.
		if (bus.wr_en) begin
			if (bus.addr == P6HS_LOW_PAIR_ADDR) begin
				next_st.field[0] = bus.wdata[P6HS_LOWER_LSB +: P6HS_FIELD_W]; // RULE1
				next_st.field[1] = bus.wdata[P6HS_UPPER_LSB +: P6HS_FIELD_W]; // RULE1
			end else if (bus.addr == P6HS_HIGH_PAIR_ADDR) begin
				next_st.field[2] = bus.wdata[P6HS_LOWER_LSB +: P6HS_FIELD_W]; // RULE2
				next_st.field[3] = bus.wdata[P6HS_UPPER_LSB +: P6HS_FIELD_W]; // RULE2
			end
		end
		// Reads answer next cycle; bits 7 and 3 are zero; unmapped addresses read zero.
		if (bus.rd_en) begin
			next_st.rvalid = 1'b1;
			if (bus.addr == P6HS_LOW_PAIR_ADDR) begin
				next_st.rdata = {1'b0, st.field[1], 1'b0, st.field[0]}; // RULE3
			end else if (bus.addr == P6HS_HIGH_PAIR_ADDR) begin
				next_st.rdata = {1'b0, st.field[3], 1'b0, st.field[2]}; // RULE3
			end else begin
				next_st.rdata = 8'h00;
			end
		end
		// Each pin is steered to its selected function only.
		for (int p = 0; p < P6HS_PINS; p++) begin
			sel = p6hs_decode(st.field[p], p);
			next_st.pin_route[p] = sel & {P6HS_FUNCS{st.pin_sync2[p]}}; // RULE18
			next_st.pout[p] = |(sel & periph_drive_in[p].out); // RULE18
			next_st.poe[p] = |(sel & periph_drive_in[p].oe); // RULE18
		end
	end

	// State register; reset gives the default timer D routing on all four pins.
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			st <= '0;
			st.field <= {P6HS_PINS{P6HS_DEFAULT_CODE}}; // RULE1 RULE2
		end else begin
			st <= next_st;
		end
	end

	assign bus.rdata = st.rdata;
	assign bus.rvalid = st.rvalid;
	assign pin_out = st.pout;
	assign pin_oe_out = st.poe;
	assign periph_in_out = st.pin_route;
	assign low_pair_out = {1'b0, st.field[1], 1'b0, st.field[0]};
	assign high_pair_out = {1'b0, st.field[3], 1'b0, st.field[2]};

endmodule : p6hs_router

// file: testbench/p6hs_asserts.sv
// Concurrent checks on the register bus that joins the two ends.
`timescale 1ns/1ps
module p6hs_asserts (
	input wire logic clock_in,
	input wire logic srst_in,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [23:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	// One clock domain, so clock and reset are named once here.
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (srst_in);
	////////////////
	property p_rd_ans; rd_en |=> rvalid; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_rv_cause; rvalid |-> $past(rd_en); endproperty
	a_rv_cause: assert property (p_rv_cause) else $error("answer without read");
	property p_rsv_rd; rvalid |-> rdata[7] == 1'b0 && rdata[3] == 1'b0; endproperty
	a_rsv_rd: assert property (p_rsv_rd) else $error("reserved bit read as one");
	property p_rsv_wr; wr_en |-> !wdata[7] && !wdata[3]; endproperty
	a_rsv_wr: assert property (p_rsv_wr) else $error("reserved bit written as one");
	property p_addr; wr_en || rd_en |-> addr inside {24'hff0056, 24'hff0057}; endproperty
	a_addr: assert property (p_addr) else $error("access outside the pair");
	// Read data only moves with its answer pulse.
	property p_hold; !rvalid |-> $stable(rdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_wr_rd; wr_en ##1 (rd_en && $stable(addr)) |=> rdata == $past(wdata, 2); endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("read back differs");
	property p_one_op; !(wr_en && rd_en); endproperty
	a_one_op: assert property (p_one_op) else $error("read and write together");
	c_write: cover property (wr_en ##1 rd_en);
	c_read: cover property (rd_en ##1 rvalid);
	c_code7: cover property (wr_en && wdata == 8'h77);
endmodule : p6hs_asserts

// file: testbench/tb_port6_upper_function_select.sv
// Self-checking bench joining the register master end and the pin router end.
`timescale 1ns/1ps
module tb_port6_upper_function_select;
	import p6hs_pkg::*;
	logic clock_in, srst_in, req_in, req_write_in, req_high_in, busy_out, read_done_out;
	logic [2:0] upper_code_in, lower_code_in;
	logic [7:0] read_data_out, low_pair_out, high_pair_out;
	logic [3:0] pin_in, pin_out, pin_oe_out;
	p6hs_periph_drive_t [3:0] drv; // Distinct pattern per pin so a wrong route shows.
	logic [3:0][5:0] pio;
	logic [3:0] pin_out_v, pin_oe_out_v; // Outputs of the reduced variant router.
	logic [3:0][5:0] pio_v;
	int fail_count, n_tests;
	p6hs_if bus_if();
	p6hs_if bus_v(); // Second bus, so the reduced variant gets the same register traffic.
	p6hs_master p6hs_master_inst (.clock_in(clock_in), .srst_in(srst_in), .bus(bus_if.master), .req_in(req_in),
		.req_write_in(req_write_in), .req_high_in(req_high_in), .upper_code_in(upper_code_in),
		.lower_code_in(lower_code_in), .busy_out(busy_out), .read_data_out(read_data_out),
		.read_done_out(read_done_out));
	p6hs_router p6hs_router_inst (.clock_in(clock_in), .srst_in(srst_in), .bus(bus_if.device), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_out(pin_oe_out), .periph_drive_in(drv), .periph_in_out(pio),
		.low_pair_out(low_pair_out), .high_pair_out(high_pair_out));
	// Variant with no timer C, no timer D unit 1 and no second converter.
	p6hs_master p6hs_master_v_inst (.clock_in(clock_in), .srst_in(srst_in), .bus(bus_v.master), .req_in(req_in),
		.req_write_in(req_write_in), .req_high_in(req_high_in), .upper_code_in(upper_code_in),
		.lower_code_in(lower_code_in), .busy_out(), .read_data_out(), .read_done_out());
	p6hs_router #(.HAS_TIMER_C(1'b0), .HAS_TIMER_D1(1'b0), .HAS_CONVERTER2(1'b0)) p6hs_router_v_inst (
		.clock_in(clock_in), .srst_in(srst_in), .bus(bus_v.device), .pin_in(pin_in),
		.pin_out(pin_out_v), .pin_oe_out(pin_oe_out_v), .periph_drive_in(drv), .periph_in_out(pio_v),
		.low_pair_out(), .high_pair_out());
	p6hs_asserts p6hs_asserts_inst (.clock_in(clock_in), .srst_in(srst_in), .wr_en(bus_if.wr_en),
		.rd_en(bus_if.rd_en), .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
		.rvalid(bus_if.rvalid));
	////////////////
	// Free-running 25 MHz clock.
	initial begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end
	task end_sim;
		$display("Comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask : chk
	// One request pulse; the master is idle whenever a task starts.
	task req(input logic wr, input logic hi, input logic [2:0] c);
		{req_in, req_write_in, req_high_in, upper_code_in, lower_code_in} = {1'b1, wr, hi, c, c};
		@(posedge clock_in);
		#1 req_in = 1'b0;
		// One idle edge, so a following request never reraises req_in in this time step.
		@(posedge clock_in);
		#1;
	endtask : req
	// Read one register, giving up after a bounded wait.
	task rd(input logic hi, input logic [7:0] exp);
		req(1'b0, hi, 3'h0);
		for (int i = 0; i < 8 && read_done_out !== 1'b1; i++) begin
			@(posedge clock_in);
			#1;
		end
		if (read_done_out !== 1'b1) begin
			fail_count++;
			end_sim;
		end
		chk("read data", {16'h0, exp}, {16'h0, read_data_out});
	endtask : rd
	// Codes 1 to 6 pick function code-1; any other code routes nothing.
	task route(input logic [2:0] c);
		logic [3:0] eo, ee, vo, ve;
		logic [3:0][5:0] ei, vi;
		{eo, ee, ei} = '0;
		for (int p = 0; p < 4; p++) begin
			if (c >= 3'h1 && c <= 3'h6) begin
				eo[p] = drv[p].out[c - 3'h1];
				ee[p] = drv[p].oe[c - 3'h1];
				ei[p][c - 3'h1] = pin_in[p];
			end
		end
		chk("pin out", {20'h0, eo}, {20'h0, pin_out});
		chk("pin enable", {20'h0, ee}, {20'h0, pin_oe_out});
		chk("periph in", ei, pio);
		// The reduced variant routes nothing for the routings it lacks.
		{vo, ve, vi} = {eo, ee, ei};
		if (c == P6HS_CODE_SEL3) {vo[0], ve[0], vi[0]} = '0;
		if (c == P6HS_CODE_SEL6) begin
			{vo[1], ve[1], vi[1]} = '0;
			{vo[3], ve[3], vi[3]} = '0;
		end
		chk("variant pin out", {20'h0, vo}, {20'h0, pin_out_v});
		chk("variant pin enable", {20'h0, ve}, {20'h0, pin_oe_out_v});
		chk("variant periph in", vi, pio_v);
	endtask : route
	task t_reset;
		rd(1'b0, P6HS_RESET_VALUE);
		rd(1'b1, P6HS_RESET_VALUE);
		route(3'h5);
		$display("t_reset done");
	endtask : t_reset
	// Every code in both fields of both registers, each read straight back.
	task t_codes;
		for (int k = 0; k < 8; k++) begin
			req(1'b1, 1'b0, 3'(k));
			req(1'b1, 1'b1, 3'(k));
			rd(1'b1, {1'b0, 3'(k), 1'b0, 3'(k)});
			rd(1'b0, {1'b0, 3'(k), 1'b0, 3'(k)});
			repeat (4) @(posedge clock_in);
			#1 route(3'(k));
		end
		$display("t_codes done");
	endtask : t_codes
	initial begin
		{req_in, req_write_in, req_high_in, upper_code_in, lower_code_in} = '0;
		{fail_count, n_tests} = '0;
		pin_in = 4'ha;
		// Peripherals drive push-pull only; no open-drain option is ever enabled.
		for (int p = 0; p < 4; p++) drv[p] = {6'h2a ^ 6'(p * 5), 6'h15 ^ 6'(p * 3)};
		// Second pass checks that reset restores defaults after code 7.
		for (int pass = 0; pass < 2; pass++) begin
			srst_in = 1'b1;
			repeat (2) @(posedge clock_in);
			#1 srst_in = 1'b0;
			t_reset;
			t_codes;
		end
		end_sim;
	end
endmodule : tb_port6_upper_function_select
